// ==== testbench/uic_conditioner_bench.sv ====
// Self-checking bench for the input conditioner
`timescale 1ns/10ps
`default_nettype none
`include "uic_map.vh"
module uic_conditioner_bench;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr, cb;
  logic [31:0] pwdata, prdata, cond_value, q;
  logic [23:0] adc_data;
  logic [1:0] adc_valid, pin_level, pullup_en, pulldown_en, adc_en;
  logic [1:0] cond_valid, chan_fault, out_enable;
  logic [7:0] codes [16] = '{8'h00, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h14,
    8'h15, 8'h1e, 8'h28, 8'h29, 8'h2a, 8'h32, 8'h33, 8'h3c, 8'h3d, 8'h3e};
  int err_count = 0;
  int n_checks = 0;
  uic_conditioner #(.GATE_CYCLES(100)) dut (.ref_clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .adc_data, .adc_valid, .pin_level, .pullup_en, .pulldown_en, .adc_en,
    .cond_value, .cond_valid, .chan_fault, .out_enable);
  uic_sensor_model sm (.ref_clk, .pullup_en, .pulldown_en, .adc_data,
    .adc_valid, .pin_level);
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (n == 9)
      chk({31'h0, pready}, 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic w(input logic [11:0] o, input logic [31:0] d);
    apb(1'b1, cb + o, d);
  endtask
  task automatic r(input logic [11:0] o, input logic [31:0] x);
    apb(1'b0, cb + o, 32'h0);
    chk(q, x);
  endtask
  task automatic s(input logic [11:0] v, input logic [31:0] x);
    sm.sample(cb[6], v);
    repeat (3) @(posedge ref_clk);
    r(`UIC_OFF_VALUE, x);
  endtask
  task automatic p(input logic lvl, input logic fl, input logic [31:0] x);
    sm.pin(0, lvl, fl);
    repeat (4) @(posedge ref_clk);
    r(`UIC_OFF_VALUE, x);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    cb = 12'h000;
    r(`UIC_OFF_FCONST, 32'ha);
    apb(1'b0, 12'h080, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    for (int i = 0; i < 16; i++) begin
      w(`UIC_OFF_TYPE, codes[i]);
      r(`UIC_OFF_TYPE, codes[i]);
    end
    r(`UIC_OFF_RMAX, 32'h1);
    w(`UIC_OFF_TYPE, `UIC_T_I420);
    r(`UIC_OFF_RMIN, 32'h333);
    w(`UIC_OFF_TYPE, `UIC_T_V5);
    r(`UIC_OFF_RMAX, 32'hfff);
    $display("regs test done");
  endtask
  task t_clamp;
    w(`UIC_OFF_PPR, 32'h5);
    w(`UIC_OFF_RMIN, 32'h100);
    w(`UIC_OFF_RMAX, 32'he00);
    w(`UIC_OFF_EMIN, 32'h080);
    w(`UIC_OFF_EMAX, 32'hf00);
    chk({30'h0, adc_en}, 32'h1);
    s(12'h050, 32'h100);
    chk({30'h0, chan_fault}, 32'h1);
    chk({30'h0, out_enable}, 32'h0);
    r(`UIC_OFF_STAT, 32'h9);
    s(12'h0c0, 32'h100);
    r(`UIC_OFF_PCT, 32'h0);
    chk({30'h0, out_enable}, 32'h1);
    s(12'hf00, 32'he00);
    r(`UIC_OFF_PCT, 32'h64);
    chk(cond_value, 32'h00000e00);
    s(12'hf01, 32'he00);
    chk({30'h0, chan_fault}, 32'h1);
    $display("range test done");
  endtask
  task t_filt;
    cb = `UIC_CH_STRIDE;
    w(`UIC_OFF_TYPE, `UIC_T_V5);
    w(`UIC_OFF_FILT, `UIC_F_MOVING);
    w(`UIC_OFF_FCONST, 32'h4);
    s(12'h400, 32'h100);
    s(12'h400, 32'h1c0);
    w(`UIC_OFF_FILT, `UIC_F_NONE);
    s(12'h300, 32'h300);
    w(`UIC_OFF_FILT, `UIC_F_REPEAT);
    w(`UIC_OFF_FCONST, 32'h2);
    sm.sample(1, 12'h100);
    @(posedge ref_clk);
    s(12'h300, 32'h200);
    s(12'h600, 32'h200);
    s(12'h800, 32'h700);
    chk(cond_value, 32'h07000e00);
    chk({30'h0, cond_valid}, 32'h3);
    $display("filter test done");
  endtask
  task t_dig;
    cb = 12'h000;
    w(`UIC_OFF_TYPE, `UIC_T_DINV);
    w(`UIC_OFF_PULL, 32'h1);
    chk({30'h0, pullup_en}, 32'h1);
    p(1'b0, 1'b1, 32'h0);
    p(1'b0, 1'b0, 32'h1);
    w(`UIC_OFF_TYPE, `UIC_T_DLATCH);
    w(`UIC_OFF_PULL, 32'h2);
    chk({30'h0, pulldown_en}, 32'h1);
    p(1'b1, 1'b0, 32'h1);
    p(1'b0, 1'b0, 32'h1);
    p(1'b1, 1'b0, 32'h0);
    w(`UIC_OFF_FILT, `UIC_F_MOVING);
    w(`UIC_OFF_TYPE, `UIC_T_DNORM);
    w(`UIC_OFF_PULL, 32'h0);
    chk({28'h0, pulldown_en, pullup_en}, 32'h0);
    p(1'b1, 1'b0, 32'h1);
    p(1'b0, 1'b0, 32'h0);
    $display("digital test done");
  endtask
  task t_freq;
    cb = `UIC_CH_STRIDE;
    w(`UIC_OFF_TYPE, `UIC_T_F1K);
    w(`UIC_OFF_FILT, `UIC_F_NONE);
    sm.freq(2'h2);
    repeat (350) @(posedge ref_clk);
    r(`UIC_OFF_FREQ, 32'ha);
    w(`UIC_OFF_PPR, 32'h2);
    repeat (350) @(posedge ref_clk);
    r(`UIC_OFF_FREQ, 32'h12c);
    r(`UIC_OFF_STAT, 32'ha);
    sm.freq(2'h0);
    w(`UIC_OFF_TYPE, `UIC_T_OFF);
    r(`UIC_OFF_VALUE, 32'h0);
    chk({30'h0, cond_valid}, 32'h1);
    $display("frequency test done");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_regs;
    t_clamp;
    t_filt;
    t_dig;
    t_freq;
    summarize;
  end
  // Tests need about 1100 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    summarize;
  end
endmodule
`default_nettype wire

// ==== testbench/uic_conditioner_chk.sv ====
// Port assertions for the input conditioner
`timescale 1ns/10ps
`default_nettype none
module uic_conditioner_chk (
  // Clock, reset and bus
  input wire ref_clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  // Channel outputs
  input wire [1:0] pullup_en,
  input wire [1:0] pulldown_en,
  input wire [1:0] adc_en,
  input wire [1:0] chan_fault,
  input wire [1:0] out_enable
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  rdy_next_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered");
  rdy_cause_a: assert property (pready |-> psel && penable)
    else $error("stray pready");
  err_rdy_a: assert property (pslverr |-> pready)
    else $error("stray pslverr");
  bad_addr_a: assert property (pready && paddr[11:7] != 5'h00 |-> pslverr)
    else $error("bad address accepted");
  pull_excl_a: assert property ((pullup_en & pulldown_en) == 2'h0)
    else $error("both pulls on");
  analog_pull_a: assert property (
    (adc_en & (pullup_en | pulldown_en)) == 2'h0) else $error("analog pull");
  fault_off_a: assert property (
    (chan_fault & $past(chan_fault) & out_enable) == 2'h0)
    else $error("faulted channel still drives");
  cover property (pslverr);
  cover property ($rose(chan_fault[0]));
  cover property ($rose(out_enable[1]));
endmodule
bind uic_conditioner uic_conditioner_chk chk (.ref_clk, .rstn, .psel,
  .penable, .paddr, .pready, .pslverr, .pullup_en, .pulldown_en, .adc_en,
  .chan_fault, .out_enable);
`default_nettype wire

// ==== testbench/uic_sensor_model.sv ====
// Behavioural sensors on both universal inputs
`timescale 1ns/10ps
`default_nettype none
module uic_sensor_model (
  // Clock and pull controls
  input wire ref_clk,
  input wire [1:0] pullup_en,
  input wire [1:0] pulldown_en,
  // Sensor side
  output logic [23:0] adc_data,
  output logic [1:0] adc_valid,
  output logic [1:0] pin_level
);
  logic [1:0] drv = 2'h0;
  logic [1:0] flt = 2'h0;
  logic [1:0] tog = 2'h0;
  logic [2:0] cnt = 3'h0;
  initial adc_valid = 2'h0;
  initial adc_data = 24'h0;
  // Floating pin: pull level, unpulled it wanders
  always_comb
    for (int i = 0; i < 2; i++)
      pin_level[i] = !flt[i] ? drv[i] :
        pullup_en[i] | (!pulldown_en[i] & cnt[0]);
  // Ten-cycle square wave on selected pins
  always @(posedge ref_clk) begin
    cnt <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
    if (cnt == 3'h4 && tog != 2'h0)
      drv <= drv ^ tog;
  end
  task automatic sample(input int ch, input logic [11:0] v);
    adc_data[ch*12 +: 12] <= v;
    adc_valid[ch] <= 1'b1;
    @(posedge ref_clk);
    adc_valid[ch] <= 1'b0;
    adc_data[ch*12 +: 12] <= ~v;
  endtask
  task automatic pin(input int ch, input logic lvl, input logic fl);
    drv[ch] <= lvl;
    flt[ch] <= fl;
  endtask
  task automatic freq(input logic [1:0] t);
    tog <= t;
  endtask
endmodule
`default_nettype wire

// ==== verilog/uic_conditioner.v ====
// Two-channel universal input conditioner with APB register access
// Operation
// - Two channels, each configured and processed independently
// - Type code: off, voltage, current, resistance, freq, PWM, digital
// - Changing sensor type reloads range and error limits for new type
// - Analog types sample 12-bit converter results
// - Pulses per revolution only used by frequency types
// - Frequency reports hertz when pulses per revolution is zero, else RPM
// - Digital types report only 1 for on, 0 for off
// - Pull option 0 none, 1 pullup, 2 pulldown for freq, PWM, digital
// - Digital inverse reads high as off, grounded as on
// - Span between min and max range maps onto 0 to 100 percent
// - Values clamp to minimum and maximum range
// - Fault when raw sample below min error or above max error
// - Output commanded by a faulted channel is switched off
// - Filtering on all types except digital ones
// - Filter code 0 none, 1 moving, 2 repeating, plus filter constant
// - No filtering forwards each sample unchanged
// - Moving average adds difference over filter constant to previous output
// - Repeating average of N samples held until next block completes
`timescale 1ns/10ps
`default_nettype none
`include "uic_map.vh"
module uic_conditioner #(
  parameter GATE_CYCLES = `UIC_GATE_NS / `UIC_CLK_NS
) (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Converter samples, one valid pulse per sample per channel
  input wire [23:0] adc_data,
  input wire [1:0] adc_valid,
  // Timer and digital pin levels
  input wire [1:0] pin_level,
  // Pull resistor controls
  output reg [1:0] pullup_en,
  output reg [1:0] pulldown_en,
  // Converter channel enables
  output reg [1:0] adc_en,
  // Conditioned values to downstream blocks
  output reg [31:0] cond_value,
  output reg [1:0] cond_valid,
  output reg [1:0] chan_fault,
  output reg [1:0] out_enable
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function is_freq;
    input [7:0] t;
    begin
      is_freq = (t >= `UIC_T_F50) && (t <= `UIC_T_F10K);
    end
  endfunction

  function is_dig;
    input [7:0] t;
    begin
      is_dig = (t >= `UIC_T_DNORM) && (t <= `UIC_T_DLATCH);
    end
  endfunction

  // Pin-timer types: frequency and both PWM ranges
  function is_timer;
    input [7:0] t;
    begin
      is_timer = is_freq(t) || t == `UIC_T_PWML || t == `UIC_T_PWMH;
    end
  endfunction

  // Pulse count is scaled to RPM only for frequency types
  function rpm_mode;
    input [7:0] t;
    input [15:0] n;
    begin
      rpm_mode = is_freq(t) && (n != 16'h0000);
    end
  endfunction

  function is_pin;
    input [7:0] t;
    begin
      is_pin = is_timer(t) || is_dig(t);
    end
  endfunction

  function is_adc;
    input [7:0] t;
    begin
      is_adc = (t >= `UIC_T_V1 && t <= `UIC_T_V10) ||
               t == `UIC_T_I20 || t == `UIC_T_I420 || t == `UIC_T_RES;
    end
  endfunction

  function [15:0] dflt_max;
    input [7:0] t;
    begin
      if (is_dig(t))
        dflt_max = `UIC_DIG_FULL;
      else if (is_adc(t))
        dflt_max = `UIC_ADC_FULL;
      else
        dflt_max = `UIC_FREQ_FULL;
    end
  endfunction

  wire apb_wr = psel && penable && pwrite && !pready;
  wire apb_rd = psel && penable && !pwrite && !pready;
  wire ch_sel = paddr[6];
  wire [11:0] off = {6'h00, paddr[5:0]};
  wire map_hi = |paddr[11:7];

  reg [31:0] gate_cnt;
  wire gate_tick = (gate_cnt == GATE_CYCLES - 1);

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      gate_cnt <= 32'h0000_0000;
    else if (gate_tick)
      gate_cnt <= 32'h0000_0000;
    else
      gate_cnt <= gate_cnt + 32'h0000_0001;
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  wire [31:0] rd_word [0:1];

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ch
      reg [7:0] stype;
      reg [1:0] pull;
      reg [15:0] ppr;
      reg [1:0] filt;
      reg [15:0] fconst;
      reg [15:0] rmin, rmax, emin, emax;
      reg [15:0] value, pct, fval;
      reg fault, ready, pin_d, latch_st;
      reg [15:0] edges;
      reg [31:0] acc;
      reg [15:0] nacc;
      reg [15:0] sample;
      reg samp_v;
      wire sel_w = apb_wr && ch_sel == c && !map_hi;
      wire [15:0] wd = pwdata[15:0];
      wire [11:0] adc_s = adc_data[c*12 +: 12];
      // Inverse mode flips the sensed level
      wire lvl = (stype == `UIC_T_DINV) ? !pin_level[c] : pin_level[c];
      wire rise = pin_level[c] && !pin_d;
      // RPM = edges * 60 / ppr, computed once per gate
      wire [31:0] rpm = ({16'h0000, edges} * 32'd60) /
                        {16'h0000, (ppr == 16'h0000 ? 16'h0001 : ppr)};

      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          stype <= `UIC_T_OFF;
          pull <= 2'h0;
          ppr <= 16'h0000;
          filt <= `UIC_F_NONE;
          fconst <= `UIC_FCONST_RST;
          rmin <= 16'h0000;
          rmax <= 16'h0000;
          emin <= 16'h0000;
          emax <= 16'h0000;
        end else if (sel_w) begin
          case (off)
            `UIC_OFF_TYPE: begin
              stype <= pwdata[7:0];
              if (pwdata[7:0] != stype) begin
                rmin <= (pwdata[7:0] == `UIC_T_I420) ? `UIC_I420_MIN
                                                     : 16'h0000;
                emin <= 16'h0000;
                rmax <= dflt_max(pwdata[7:0]);
                emax <= dflt_max(pwdata[7:0]);
              end
            end
            `UIC_OFF_PULL: pull <= pwdata[1:0];
            `UIC_OFF_PPR: ppr <= wd;
            `UIC_OFF_FILT: filt <= pwdata[1:0];
            `UIC_OFF_FCONST: fconst <= (wd == 16'h0000) ? 16'h0001 : wd;
            `UIC_OFF_RMIN: rmin <= wd;
            `UIC_OFF_RMAX: rmax <= wd;
            `UIC_OFF_EMIN: emin <= wd;
            `UIC_OFF_EMAX: emax <= wd;
            default: ;
          endcase
        end
      end

      // Sample acquisition
      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          pin_d <= 1'b0;
          latch_st <= 1'b0;
          edges <= 16'h0000;
          fval <= 16'h0000;
          sample <= 16'h0000;
          samp_v <= 1'b0;
        end else begin
          pin_d <= pin_level[c];
          samp_v <= 1'b0;
          if (is_timer(stype)) begin
            if (gate_tick) begin
              edges <= rise ? 16'h0001 : 16'h0000;
              // PWM counted as edge rate, duty left to timers
              // RPM above 16 bits wraps: keep ppr and speed in range
              if (rpm_mode(stype, ppr)) begin
                fval <= rpm[15:0];
                sample <= rpm[15:0];
              end else begin
                fval <= edges;
                sample <= edges;
              end
              samp_v <= 1'b1;
            end else if (rise) begin
              edges <= edges + 16'h0001;
            end
          end else if (is_adc(stype)) begin
            if (adc_valid[c]) begin
              sample <= {4'h0, adc_s};
              samp_v <= 1'b1;
            end
          end else if (is_dig(stype)) begin
            if (stype == `UIC_T_DLATCH && rise)
              latch_st <= !latch_st;
            sample <= (stype == `UIC_T_DLATCH) ? {15'h0000, latch_st}
                                               : {15'h0000, lvl};
            samp_v <= 1'b1;
          end
        end
      end

      // Filter, clamp and fault
      reg [15:0] clamped;
      reg signed [17:0] diff;
      always @* begin
        clamped = sample;
        if (sample < rmin)
          clamped = rmin;
        else if (sample > rmax)
          clamped = rmax;
        diff = $signed({2'b00, clamped}) - $signed({2'b00, value});
      end

      wire [31:0] acc_n = acc + {16'h0000, clamped};
      wire [17:0] step = diff / $signed({2'b00, fconst});
      wire [31:0] avg = acc_n / {16'h0000, fconst};

      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          value <= 16'h0000;
          acc <= 32'h0000_0000;
          nacc <= 16'h0000;
          fault <= 1'b0;
          ready <= 1'b0;
        end else if (stype == `UIC_T_OFF) begin
          value <= 16'h0000;
          acc <= 32'h0000_0000;
          nacc <= 16'h0000;
          fault <= 1'b0;
          ready <= 1'b0;
        end else if (samp_v) begin
          fault <= (sample < emin) || (sample > emax);
          if (is_dig(stype) || filt == `UIC_F_NONE) begin
            value <= clamped;
            ready <= 1'b1;
          end else if (filt == `UIC_F_MOVING) begin
            value <= value + step[15:0];
            ready <= 1'b1;
          end else begin
            if (nacc + 16'h0001 >= fconst) begin
              value <= avg[15:0];
              acc <= 32'h0000_0000;
              nacc <= 16'h0000;
              ready <= 1'b1;
            end else begin
              acc <= acc_n;
              nacc <= nacc + 16'h0001;
            end
          end
        end
      end

      // Percent of useful span, 0..100
      wire [15:0] span = (rmax > rmin) ? rmax - rmin : 16'h0001;
      wire [31:0] pct_w = ({16'h0000, value - rmin} * 32'd100) /
                          {16'h0000, span};

      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          pct <= 16'h0000;
          pullup_en[c] <= 1'b0;
          pulldown_en[c] <= 1'b0;
          adc_en[c] <= 1'b0;
          cond_value[c*16 +: 16] <= 16'h0000;
          cond_valid[c] <= 1'b0;
          chan_fault[c] <= 1'b0;
          out_enable[c] <= 1'b0;
        end else begin
          pct <= (value <= rmin) ? 16'h0000 : pct_w[15:0];
          pullup_en[c] <= is_pin(stype) && pull == 2'h1;
          pulldown_en[c] <= is_pin(stype) && pull == 2'h2;
          adc_en[c] <= is_adc(stype);
          cond_value[c*16 +: 16] <= value;
          cond_valid[c] <= ready;
          chan_fault[c] <= fault;
          // Fault drops the commanded output
          out_enable[c] <= ready && !fault;
        end
      end

      // Status word assembled from the mapped bit positions
      reg [31:0] status;
      always @* begin
        status = 32'h0000_0000;
        status[`UIC_ST_FAULT] = fault;
        status[`UIC_ST_RPM] = rpm_mode(stype, ppr);
        status[`UIC_ST_DIG] = is_dig(stype);
        status[`UIC_ST_READY] = ready;
      end

      reg [31:0] rw;
      always @* begin
        case (off)
          `UIC_OFF_TYPE: rw = {24'h000000, stype};
          `UIC_OFF_PULL: rw = {30'h0, pull};
          `UIC_OFF_PPR: rw = {16'h0000, ppr};
          `UIC_OFF_FILT: rw = {30'h0, filt};
          `UIC_OFF_FCONST: rw = {16'h0000, fconst};
          `UIC_OFF_RMIN: rw = {16'h0000, rmin};
          `UIC_OFF_RMAX: rw = {16'h0000, rmax};
          `UIC_OFF_EMIN: rw = {16'h0000, emin};
          `UIC_OFF_EMAX: rw = {16'h0000, emax};
          `UIC_OFF_STAT: rw = status;
          `UIC_OFF_VALUE: rw = {16'h0000, value};
          `UIC_OFF_PCT: rw = {16'h0000, pct};
          `UIC_OFF_FREQ: rw = {16'h0000, fval};
          default: rw = 32'h0000_0000;
        endcase
      end
      assign rd_word[c] = rw;
    end
  endgenerate

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------
  wire bad_addr = map_hi || paddr[1:0] != 2'h0 || off > `UIC_OFF_FREQ;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= (apb_wr || apb_rd) && bad_addr;
      if (apb_rd)
        prdata <= bad_addr ? 32'h0000_0000 : rd_word[ch_sel];
    end
  end

endmodule
`default_nettype wire

// ==== verilog/uic_map.vh ====
// Register offsets, field codes and reset values of the input conditioner
`ifndef UIC_MAP_VH
`define UIC_MAP_VH
// Per-channel register offsets (channel 1 adds UIC_CH_STRIDE)
`define UIC_CH_STRIDE 12'h040
`define UIC_OFF_TYPE 12'h000
`define UIC_OFF_PULL 12'h004
`define UIC_OFF_PPR 12'h008
`define UIC_OFF_FILT 12'h00c
`define UIC_OFF_FCONST 12'h010
`define UIC_OFF_RMIN 12'h014
`define UIC_OFF_RMAX 12'h018
`define UIC_OFF_EMIN 12'h01c
`define UIC_OFF_EMAX 12'h020
`define UIC_OFF_STAT 12'h024
`define UIC_OFF_VALUE 12'h028
`define UIC_OFF_PCT 12'h02c
`define UIC_OFF_FREQ 12'h030
// Sensor type codes
`define UIC_T_OFF 8'h00
`define UIC_T_V1 8'h0a
`define UIC_T_V25 8'h0b
`define UIC_T_V5 8'h0c
`define UIC_T_V10 8'h0d
`define UIC_T_I20 8'h14
`define UIC_T_I420 8'h15
`define UIC_T_RES 8'h1e
`define UIC_T_F50 8'h28
`define UIC_T_F1K 8'h29
`define UIC_T_F10K 8'h2a
`define UIC_T_PWML 8'h32
`define UIC_T_PWMH 8'h33
`define UIC_T_DNORM 8'h3c
`define UIC_T_DINV 8'h3d
`define UIC_T_DLATCH 8'h3e
// Filter codes
`define UIC_F_NONE 2'h0
`define UIC_F_MOVING 2'h1
`define UIC_F_REPEAT 2'h2
// Default limits reloaded on a type change, and filter constant reset value
`define UIC_ADC_FULL 16'h0fff
`define UIC_DIG_FULL 16'h0001
`define UIC_FREQ_FULL 16'hffff
`define UIC_I420_MIN 16'h0333
`define UIC_FCONST_RST 16'h000a
// Status bits
`define UIC_ST_FAULT 0
`define UIC_ST_RPM 1
`define UIC_ST_DIG 2
`define UIC_ST_READY 3
// Frequency gate time: 1 s at 40 MHz
`define UIC_GATE_NS 32'd1000000000
`define UIC_CLK_NS 32'd25
`endif
